// file: verilog/nvmc_defines.svh
// constants of the nvm controller: offsets, fields, commands, timing
`ifndef NVMC_DEFINES_SVH
`define NVMC_DEFINES_SVH
// register offsets from the controller base
`define NVMC_OFF_LOC_LOW 8'h00
`define NVMC_OFF_LOC_HIGH 8'h01
`define NVMC_OFF_LOC_EXT 8'h02
`define NVMC_OFF_VAL_LOW 8'h04
`define NVMC_OFF_VAL_MID 8'h05
`define NVMC_OFF_VAL_HIGH 8'h06
`define NVMC_OFF_OPCODE 8'h0a
`define NVMC_OFF_EXEC_CTRL 8'h0b
`define NVMC_OFF_OPT_CTRL 8'h0c
`define NVMC_OFF_STATUS 8'h0f
`define NVMC_REG_BASE 24'h0001c0
// field positions
`define NVMC_BIT_TRIGGER 0
`define NVMC_BIT_WINDOW_EN 3
`define NVMC_BIT_FLASH_PS 2
`define NVMC_BIT_EE_PS 1
`define NVMC_BIT_LOCKOUT 0
`define NVMC_BIT_EXT_CMD 6
// reset values
`define NVMC_RST_BYTE 8'h00
`define NVMC_RST_OPCODE 7'h00
// eeprom window in data space
`define NVMC_EE_MAP_BASE 24'h001000
`define NVMC_EE_BYTES 2048
`define NVMC_EE_PAGE_BYTES 32
// operation codes handled locally
`define NVMC_CMD_EE_LOAD 7'h33
`define NVMC_CMD_EE_PAGE_WRITE 7'h35
`define NVMC_CMD_EE_FLUSH 7'h36
// read wait cycles before the answer cycle
`define NVMC_EE_READ_CYC 2'd2
`define NVMC_EE_BURST_CYC 2'd1
// idle-sleep wake-up time and clock rate
`define NVMC_IDLE_WAKE_NS 100
`define NVMC_CLK_MHZ 200
`define NVMC_WAKE_CYC (((`NVMC_IDLE_WAKE_NS * `NVMC_CLK_MHZ) + 999) / 1000)
`endif

// file: verilog/nvmc_pkg.sv
// types shared by the nvm controller files
package nvmc_pkg;
	typedef logic [7:0] nvmc_byte_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EE_WAKE, ST_EE_READ} nvmc_state_e;
endpackage

// file: verilog/nvmc_wake_timer.sv
// stalls an access to a powered-down memory for the idle wake-up time
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_defines.svh"
module nvmc_wake_timer #(
	parameter int WAKE_CYCLES = `NVMC_WAKE_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic wakeReq,
	output logic stall_q,
	output logic awake_q
);
	import nvmc_pkg::*;
	localparam int WC = (WAKE_CYCLES < 1) ? 1 : WAKE_CYCLES;
	logic [15:0] count_q;
	// stall stands for exactly WC cycles, one per counted wake-up cycle
	wire logic countDone = (count_q == 16'(WC));

	// the section stays awake while the access is held, then sleeps again
	always_ff @(posedge sys_clk) begin
		if (reset || !wakeReq) begin
			count_q <= 16'h0000;
			awake_q <= 1'b0;
			stall_q <= 1'b0;
		end else if (!awake_q) begin
			count_q <= countDone ? count_q : count_q + 16'h0001;
			awake_q <= countDone;
			stall_q <= !countDone;
		end
	end
endmodule // nvmc_wake_timer
`default_nettype wire

// file: verilog/nvmc_page_buffer.sv
// eeprom page buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module nvmc_page_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	// contents need no reset, the loaded flag tells what is valid
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData_q <= mem[rdAddr];
	end
endmodule // nvmc_page_buffer
`default_nettype wire

// file: verilog/nvmc_top.sv
// nvm controller registers, mapped eeprom window and power reduction
// Summary of operation
// - eeprom stays in its own space unless software enables the window
// - enabled window starts at data address 0x1000 and reaches the eeprom
// - eeprom is handled bytewise and by whole pages
// - buffer load answers in one cycle, single eeprom read in three
// - sequential burst reads answer every second cycle after the first
// - three location bytes form a 24-bit location, low byte is bits 7:0
// - top location byte serves flash sections only, others serve all
// - value word resets to zero and takes crc results
// - middle value byte for flash, low value byte for all memories
// - opcode is bits 6:0, bit 6 marks external programming codes
// - writing one to trigger starts the opcode, only when guard is open
// - window enable bit 3 maps eeprom for loads and stores
// - flash power save turns off the section not executing
// - access to the sleeping flash section stalls for idle wake time
// - eeprom power save sleeps eeprom, accesses stall for wake time
// - lockout bit set under guard blocks self-programming until reset
// - busy flag set at start, held, cleared when operation finishes
// - buffer loaded flag set on any load, cleared by page write or flush
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_defines.svh"
module nvmc_top #(
	parameter int EE_BYTES = `NVMC_EE_BYTES,
	parameter int PAGE_BYTES = `NVMC_EE_PAGE_BYTES,
	parameter int WAKE_CYCLES = `NVMC_WAKE_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [23:0] busAddr,
	input wire logic busReq,
	input wire logic busWrite,
	input wire nvmc_pkg::nvmc_byte_t busWdata,
	output nvmc_pkg::nvmc_byte_t busRdata_q,
	output logic busReady_q,
	input wire logic configGuardOpen,
	input wire logic execInBoot,
	input wire logic flashReq,
	input wire logic flashReqBoot,
	output logic flashStall_q,
	input wire logic selfProgStoreReq,
	output logic selfProgStoreGo_q,
	output logic nvmStart_q,
	output logic [6:0] nvmCmd_q,
	output logic [23:0] nvmLocation_q,
	output logic [23:0] nvmValue_q,
	input wire logic nvmDone,
	input wire logic crcValid,
	input wire logic [23:0] crcResult,
	output logic eeArrayRead_q,
	output logic [$clog2(EE_BYTES)-1:0] eeArrayAddr_q,
	input wire nvmc_pkg::nvmc_byte_t eeArrayData,
	input wire logic [$clog2(PAGE_BYTES)-1:0] eeBufRdAddr,
	output nvmc_pkg::nvmc_byte_t eeBufRdData_q,
	output logic eeWindowEn_q,
	output logic flashPowerSave_q,
	output logic eepromPowerSave_q,
	output logic selfProgLockout_q,
	output logic nvm_program_busy_q,
	output logic eeBufLoaded_q
);
	import nvmc_pkg::*;
	localparam int AW = $clog2(EE_BYTES);
	localparam int PW = $clog2(PAGE_BYTES);
	localparam logic [23:0] WIN_TOP = 24'(`NVMC_EE_MAP_BASE + EE_BYTES);

	nvmc_state_e state_q, state_d;
	nvmc_byte_t locLow_q, locHigh_q, locExt_q;
	nvmc_byte_t valLow_q, valMid_q, valHigh_q;
	logic [1:0] readCnt_q;
	logic [23:0] reqAddr_q;
	logic reqWrite_q;
	nvmc_byte_t reqData_q;
	logic lastWasEeRead_q;
	logic eeStall;
	logic eeAwake;

	// register decode, shared by every register select
	function automatic logic regHit(input logic [23:0] a, input logic [7:0] off);
		regHit = (a == (`NVMC_REG_BASE + {16'h0000, off}));
	endfunction

	function automatic logic inWindow(input logic [23:0] a);
		inWindow = (a >= `NVMC_EE_MAP_BASE) && (a < WIN_TOP);
	endfunction

	// one answer per request; only a sequential load is taken in the answer cycle
	wire logic eeSel = eeWindowEn_q && inWindow(busAddr);
	wire logic burstHit = busReady_q && lastWasEeRead_q && eeSel && !busWrite &&
		(busAddr == reqAddr_q + 24'h000001);
	wire logic accept = busReq && (state_q == ST_IDLE) && (!busReady_q || burstHit);
	wire logic regSel = regHit(busAddr, `NVMC_OFF_LOC_LOW) ||
		regHit(busAddr, `NVMC_OFF_LOC_HIGH) || regHit(busAddr, `NVMC_OFF_LOC_EXT) ||
		regHit(busAddr, `NVMC_OFF_VAL_LOW) || regHit(busAddr, `NVMC_OFF_VAL_MID) ||
		regHit(busAddr, `NVMC_OFF_VAL_HIGH) || regHit(busAddr, `NVMC_OFF_OPCODE) ||
		regHit(busAddr, `NVMC_OFF_EXEC_CTRL) || regHit(busAddr, `NVMC_OFF_OPT_CTRL) ||
		regHit(busAddr, `NVMC_OFF_STATUS);
	wire logic regWr = accept && busWrite;
	wire logic wrLocLow = regWr && regHit(busAddr, `NVMC_OFF_LOC_LOW);
	wire logic wrLocHigh = regWr && regHit(busAddr, `NVMC_OFF_LOC_HIGH);
	wire logic wrLocExt = regWr && regHit(busAddr, `NVMC_OFF_LOC_EXT);
	wire logic wrValLow = regWr && regHit(busAddr, `NVMC_OFF_VAL_LOW);
	wire logic wrValMid = regWr && regHit(busAddr, `NVMC_OFF_VAL_MID);
	wire logic wrValHigh = regWr && regHit(busAddr, `NVMC_OFF_VAL_HIGH);
	wire logic wrOpcode = regWr && regHit(busAddr, `NVMC_OFF_OPCODE);
	wire logic wrExec = regWr && regHit(busAddr, `NVMC_OFF_EXEC_CTRL);
	wire logic wrOpt = regWr && regHit(busAddr, `NVMC_OFF_OPT_CTRL);

	// trigger and lockout only move inside the unlock window
	wire logic trigger = wrExec && busWdata[`NVMC_BIT_TRIGGER] && configGuardOpen
		&& !nvm_program_busy_q && !nvmCmd_q[`NVMC_BIT_EXT_CMD];
	wire logic lockSet = wrOpt && busWdata[`NVMC_BIT_LOCKOUT] && configGuardOpen;
	wire logic bufClear = trigger && ((nvmCmd_q == `NVMC_CMD_EE_PAGE_WRITE) ||
		(nvmCmd_q == `NVMC_CMD_EE_FLUSH));

	// eeprom accesses: direct, after wake-up, and command-driven loads
	wire logic [23:0] eeOff = busAddr - `NVMC_EE_MAP_BASE;
	wire logic [23:0] reqOff = reqAddr_q - `NVMC_EE_MAP_BASE;
	wire logic eeWrNow = accept && eeSel && busWrite && !eepromPowerSave_q;
	wire logic eeWrLate = (state_q == ST_EE_WAKE) && eeAwake && reqWrite_q;
	wire logic cmdLoad = wrValLow && (nvmCmd_q == `NVMC_CMD_EE_LOAD);
	wire logic bufWrEn = eeWrNow || eeWrLate || cmdLoad;
	wire logic [PW-1:0] bufWrAddr = eeWrNow ? eeOff[PW-1:0] :
		eeWrLate ? reqOff[PW-1:0] : locLow_q[PW-1:0];
	wire nvmc_byte_t bufWrData = eeWrLate ? reqData_q : busWdata;
	wire logic eeRdNow = accept && eeSel && !busWrite && !eepromPowerSave_q;

	// register read selection, reserved bits read as zero
	wire nvmc_byte_t statusByte = {nvm_program_busy_q, 6'h00, eeBufLoaded_q};
	wire nvmc_byte_t optByte = {4'h0, eeWindowEn_q, flashPowerSave_q,
		eepromPowerSave_q, selfProgLockout_q};
	wire nvmc_byte_t regRdata =
		regHit(busAddr, `NVMC_OFF_LOC_LOW) ? locLow_q :
		regHit(busAddr, `NVMC_OFF_LOC_HIGH) ? locHigh_q :
		regHit(busAddr, `NVMC_OFF_LOC_EXT) ? locExt_q :
		regHit(busAddr, `NVMC_OFF_VAL_LOW) ? valLow_q :
		regHit(busAddr, `NVMC_OFF_VAL_MID) ? valMid_q :
		regHit(busAddr, `NVMC_OFF_VAL_HIGH) ? valHigh_q :
		regHit(busAddr, `NVMC_OFF_OPCODE) ? {1'b0, nvmCmd_q} :
		regHit(busAddr, `NVMC_OFF_OPT_CTRL) ? optByte :
		regHit(busAddr, `NVMC_OFF_STATUS) ? statusByte : `NVMC_RST_BYTE;

	// flash section that is asleep under power save
	wire logic flashWakeReq = flashPowerSave_q && flashReq && (flashReqBoot != execInBoot);
	wire logic eeWakeReq = eepromPowerSave_q && (state_q == ST_EE_WAKE);

	nvmc_wake_timer #(.WAKE_CYCLES(WAKE_CYCLES)) flashWake (
		.sys_clk(sys_clk),
		.reset(reset),
		.wakeReq(flashWakeReq),
		.stall_q(flashStall_q),
		.awake_q()
	);

	nvmc_wake_timer #(.WAKE_CYCLES(WAKE_CYCLES)) eeWake (
		.sys_clk(sys_clk),
		.reset(reset),
		.wakeReq(eeWakeReq),
		.stall_q(eeStall),
		.awake_q(eeAwake)
	);

	nvmc_page_buffer #(.WIDTH(8), .DEPTH(PAGE_BYTES)) pageBuf (
		.sys_clk(sys_clk),
		.wrEn(bufWrEn),
		.wrAddr(bufWrAddr),
		.wrData(bufWrData),
		.rdAddr(eeBufRdAddr),
		.rdData_q(eeBufRdData_q)
	);

	// access sequencer for the mapped window
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (accept && eeSel && eepromPowerSave_q) begin
					state_d = ST_EE_WAKE;
				end else if (eeRdNow) begin
					state_d = ST_EE_READ;
				end
			end
			ST_EE_WAKE: begin
				if (eeAwake) begin
					state_d = reqWrite_q ? ST_IDLE : ST_EE_READ;
				end
			end
			ST_EE_READ: begin
				if (readCnt_q == `NVMC_EE_BURST_CYC) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		state_q <= reset ? ST_IDLE : state_d;
	end

	// read latency: two waits normally, one for a sequential burst word
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			readCnt_q <= 2'd0;
		end else if (eeRdNow) begin
			readCnt_q <= burstHit ? `NVMC_EE_BURST_CYC : `NVMC_EE_READ_CYC;
		end else if (state_q == ST_EE_WAKE && eeAwake) begin
			readCnt_q <= `NVMC_EE_READ_CYC;
		end else if (state_q == ST_EE_READ) begin
			readCnt_q <= readCnt_q - 2'd1;
		end
	end

	// request capture for wake-up waits and the burst address match
	always_ff @(posedge sys_clk) begin
		if (accept) begin
			reqAddr_q <= busAddr;
			reqWrite_q <= busWrite;
			reqData_q <= busWdata;
			lastWasEeRead_q <= eeSel && !busWrite;
		end
	end

	// array port held high for the whole read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			eeArrayRead_q <= 1'b0;
			eeArrayAddr_q <= '0;
		end else begin
			eeArrayRead_q <= (state_d == ST_EE_READ);
			if (eeRdNow) begin
				eeArrayAddr_q <= eeOff[AW-1:0];
			end else if (state_q == ST_EE_WAKE) begin
				eeArrayAddr_q <= reqOff[AW-1:0];
			end
		end
	end

	// bus answer: registers and buffer loads next cycle, reads when data lands
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			busReady_q <= 1'b0;
			busRdata_q <= `NVMC_RST_BYTE;
		end else if (accept && regSel) begin
			busReady_q <= 1'b1;
			busRdata_q <= regRdata;
		end else if (state_q == ST_EE_READ && readCnt_q == `NVMC_EE_BURST_CYC) begin
			busReady_q <= 1'b1;
			busRdata_q <= eeArrayData;
		end else begin
			busReady_q <= eeWrNow || eeWrLate;
		end
	end

	// location and value bytes; a crc result overrides a software write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			locLow_q <= `NVMC_RST_BYTE;
			locHigh_q <= `NVMC_RST_BYTE;
			locExt_q <= `NVMC_RST_BYTE;
		end else begin
			locLow_q <= wrLocLow ? busWdata : locLow_q;
			locHigh_q <= wrLocHigh ? busWdata : locHigh_q;
			locExt_q <= wrLocExt ? busWdata : locExt_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			{valHigh_q, valMid_q, valLow_q} <= {3{`NVMC_RST_BYTE}};
		end else if (crcValid) begin
			{valHigh_q, valMid_q, valLow_q} <= crcResult;
		end else begin
			valLow_q <= wrValLow ? busWdata : valLow_q;
			valMid_q <= wrValMid ? busWdata : valMid_q;
			valHigh_q <= wrValHigh ? busWdata : valHigh_q;
		end
	end

	// outward copies for the array sequencer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nvmLocation_q <= 24'h000000;
			nvmValue_q <= 24'h000000;
		end else begin
			nvmLocation_q <= {locExt_q, locHigh_q, locLow_q};
			nvmValue_q <= {valHigh_q, valMid_q, valLow_q};
		end
	end

	// opcode and option bits; bit 7 of a write is dropped
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nvmCmd_q <= `NVMC_RST_OPCODE;
			eeWindowEn_q <= 1'b0;
			flashPowerSave_q <= 1'b0;
			eepromPowerSave_q <= 1'b0;
		end else begin
			nvmCmd_q <= wrOpcode ? busWdata[6:0] : nvmCmd_q;
			if (wrOpt) begin
				eeWindowEn_q <= busWdata[`NVMC_BIT_WINDOW_EN];
				flashPowerSave_q <= busWdata[`NVMC_BIT_FLASH_PS];
				eepromPowerSave_q <= busWdata[`NVMC_BIT_EE_PS];
			end
		end
	end

	// lockout is sticky: written zeros never clear it, only reset does
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			selfProgLockout_q <= 1'b0;
			selfProgStoreGo_q <= 1'b0;
		end else begin
			selfProgLockout_q <= selfProgLockout_q || lockSet;
			selfProgStoreGo_q <= selfProgStoreReq && !selfProgLockout_q;
		end
	end

	// start pulse and busy; done cannot meet a start since busy gates it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nvmStart_q <= 1'b0;
			nvm_program_busy_q <= 1'b0;
		end else begin
			nvmStart_q <= trigger;
			nvm_program_busy_q <= trigger || (nvm_program_busy_q && !nvmDone);
		end
	end

	// a load in the same cycle as a clear keeps the flag set
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			eeBufLoaded_q <= 1'b0;
		end else begin
			eeBufLoaded_q <= bufWrEn || (eeBufLoaded_q && !bufClear);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_trigger_guarded: assert property (nvmStart_q |-> $past(configGuardOpen && wrExec))
		else $error("start without an open guard");
	a_ext_code_ignored: assert property (nvmStart_q |-> !$past(nvmCmd_q[`NVMC_BIT_EXT_CMD]))
		else $error("external code was started");
	a_busy_holds: assert property (nvmStart_q |-> nvm_program_busy_q until_with nvmDone)
		else $error("busy dropped early");
	a_lock_sticky: assert property (selfProgLockout_q |=> selfProgLockout_q ##1 !selfProgStoreGo_q)
		else $error("lockout cleared or store passed");
	a_read_three: assert property (eeRdNow && !burstHit |-> ##1 !busReady_q ##1 !busReady_q ##1 busReady_q)
		else $error("single read not three cycles");
	a_burst_two: assert property (eeRdNow && burstHit |-> ##1 !busReady_q ##1 busReady_q)
		else $error("burst word not two cycles");
	a_load_one: assert property (eeWrNow |=> busReady_q && eeBufLoaded_q)
		else $error("buffer load not answered in one cycle");
	a_window_off: assert property ($rose(eeArrayRead_q) |-> $past(eeWindowEn_q, 1))
		else $error("eeprom reached with window off");
	a_crc_value: assert property (crcValid |=> ##1 nvmValue_q == $past(crcResult, 2))
		else $error("crc result not in value word");
	a_flash_stall: assert property ($rose(flashWakeReq) |=> flashStall_q)
		else $error("sleeping flash access not stalled");

	c_ee_read: cover property (eeRdNow ##3 busReady_q);
	c_burst: cover property (eeRdNow && burstHit);
	c_exec: cover property (nvmStart_q ##[1:20] !nvm_program_busy_q);
	c_ee_wake: cover property (eeStall ##1 !eeStall);
endmodule // nvmc_top
`default_nettype wire

// file: testbench/nvmc_far_model.sv
// far side model: eeprom array contents and the nvm operation engine
`timescale 1ns/1ps
`default_nettype none
module nvmc_far_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic eeRead,
	input wire logic [10:0] eeAddr,
	input wire logic opStart,
	input wire logic [7:0] doneDelay,
	output logic [7:0] eeData,
	output logic opDone
);
	logic [7:0] lastData_q;
	logic [7:0] cnt_q;
	logic run_q;
	// array byte is its address folded with a mask; idle lines toggle, never hold
	assign eeData = eeRead ? (eeAddr[7:0] ^ 8'h5a) : ~lastData_q;
	always_ff @(posedge sys_clk) begin
		lastData_q <= reset ? 8'h00 : eeData;
	end
	// an operation runs doneDelay cycles, then reports completion once
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			run_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (opStart) begin
			run_q <= 1'b1;
			cnt_q <= doneDelay;
		end else if (run_q && cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			run_q <= 1'b0;
		end
	end
	assign opDone = run_q && cnt_q == 8'h00;
endmodule // nvmc_far_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the nvm controller
`timescale 1ns/1ps
`default_nettype none
`include "nvmc_defines.svh"
module testbench;
	import nvmc_pkg::*;
	localparam int WAKE = 2;
	typedef struct {logic [7:0] off; logic [7:0] wd; logic [7:0] ex;} nvmc_row_s;
	logic sys_clk = 1'b0;
	logic reset, busReq, busWrite, busReady, guardOpen, execInBoot, flashReq, flashBoot;
	logic [23:0] busAddr, nvmLoc, nvmVal, crcResult;
	logic [7:0] busWdata, busRdata, eeData, bufRdData, rdata, doneDelay;
	logic flashStall, spmReq, spmGo, nvmStart, nvmDone, crcValid, eeRead;
	logic winEn, flashPs, eePs, lockout, busy, loaded;
	logic [6:0] nvmCmd;
	logic [10:0] eeAddr;
	logic [4:0] bufRdAddr;
	int errTotal = 0;
	int checksDone = 0;
	int lat, starts = 0, n;
	nvmc_row_s rows[7] = '{'{8'h00, 8'h11, 8'h11}, '{8'h01, 8'h22, 8'h22},
		'{8'h02, 8'h03, 8'h03}, '{8'h04, 8'h44, 8'h44}, '{8'h05, 8'h55, 8'h55},
		'{8'h06, 8'h66, 8'h66}, '{8'h0a, 8'h45, 8'h45}};

	always #2.5 sys_clk = ~sys_clk;

	nvmc_top #(.WAKE_CYCLES(WAKE)) uut (.sys_clk(sys_clk), .reset(reset),
		.busAddr(busAddr), .busReq(busReq), .busWrite(busWrite), .busWdata(busWdata),
		.busRdata_q(busRdata), .busReady_q(busReady), .configGuardOpen(guardOpen),
		.execInBoot(execInBoot), .flashReq(flashReq), .flashReqBoot(flashBoot),
		.flashStall_q(flashStall), .selfProgStoreReq(spmReq), .selfProgStoreGo_q(spmGo),
		.nvmStart_q(nvmStart), .nvmCmd_q(nvmCmd), .nvmLocation_q(nvmLoc),
		.nvmValue_q(nvmVal), .nvmDone(nvmDone), .crcValid(crcValid),
		.crcResult(crcResult), .eeArrayRead_q(eeRead), .eeArrayAddr_q(eeAddr),
		.eeArrayData(eeData), .eeBufRdAddr(bufRdAddr), .eeBufRdData_q(bufRdData),
		.eeWindowEn_q(winEn), .flashPowerSave_q(flashPs), .eepromPowerSave_q(eePs),
		.selfProgLockout_q(lockout), .nvm_program_busy_q(busy), .eeBufLoaded_q(loaded));

	nvmc_far_model far (.sys_clk(sys_clk), .reset(reset), .eeRead(eeRead),
		.eeAddr(eeAddr), .opStart(nvmStart), .doneDelay(doneDelay), .eeData(eeData),
		.opDone(nvmDone));

	// count operation starts seen at the port
	always @(posedge sys_clk) begin
		if (nvmStart === 1'b1) starts++;
	end

	task automatic reportAndStop();
		$display("checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// raise or change a request at a falling edge; bounded wait for the answer
	task automatic bus(input logic [23:0] a, input logic w, input logic [7:0] d);
		busAddr = a;
		busWrite = w;
		busWdata = d;
		busReq = 1'b1;
		lat = 0;
		do begin
			@(negedge sys_clk);
			lat++;
		end while (busReady !== 1'b1 && lat < 12);
		rdata = busRdata;
	endtask

	task automatic idle();
		busReq = 1'b0;
		@(negedge sys_clk);
	endtask

	function automatic logic [23:0] ra(input logic [7:0] o);
		return `NVMC_REG_BASE | {16'h0000, o};
	endfunction

	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		bus(ra(o), 1'b1, d);
		idle();
	endtask

	task automatic rd(input logic [7:0] o);
		bus(ra(o), 1'b0, 8'h00);
		idle();
	endtask

	task automatic waitIdle();
		for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge sys_clk);
		chk(24'(busy), 24'h0);
	endtask

	// counts stall cycles over a fixed span of flash access
	task automatic stallSpan();
		n = 0;
		repeat (12) begin
			@(negedge sys_clk);
			if (flashStall === 1'b1) n++;
		end
	endtask

	initial begin
		#20000;
		errTotal++;
		reportAndStop();
	end

	initial begin
		{reset, busReq, busWrite, guardOpen, execInBoot, flashReq, flashBoot} = 7'h40;
		{spmReq, crcValid} = 2'b00;
		busAddr = 24'h000000;
		busWdata = 8'h00;
		crcResult = 24'h000000;
		bufRdAddr = 5'h00;
		doneDelay = 8'h0a;
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		// register table: reset value, write, read back
		foreach (rows[i]) begin
			rd(rows[i].off);
			chk(24'(rdata), 24'h000000);
			wr(rows[i].off, rows[i].wd);
			rd(rows[i].off);
			chk(24'(rdata), 24'(rows[i].ex));
		end
		chk(nvmLoc, 24'h032211);
		chk(nvmVal, 24'h665544);
		chk(24'(nvmCmd), 24'h000045);
		// a code with bit 6 set is not started even with the guard open
		guardOpen = 1'b1;
		wr(`NVMC_OFF_EXEC_CTRL, 8'h01);
		chk(24'(starts), 24'h000000);
		wr(`NVMC_OFF_OPCODE, {1'b0, `NVMC_CMD_EE_FLUSH});
		guardOpen = 1'b0;
		wr(`NVMC_OFF_EXEC_CTRL, 8'h01);
		chk(24'(starts), 24'h000000);
		// window still off: loads and stores there are never taken
		bus(`NVMC_EE_MAP_BASE, 1'b0, 8'h00);
		chk(24'(eeRead), 24'h000000);
		bus(`NVMC_EE_MAP_BASE + 24'h5, 1'b1, 8'ha5);
		idle();
		chk(24'(lat), 24'd12);
		chk(24'(loaded), 24'h000000);
		wr(`NVMC_OFF_OPT_CTRL, 8'h08);
		chk(24'(winEn), 24'h000001);
		bus(`NVMC_EE_MAP_BASE + 24'h5, 1'b1, 8'ha5);
		chk(24'(lat), 24'h000001);
		idle();
		chk(24'(loaded), 24'h000001);
		bufRdAddr = 5'h05;
		@(negedge sys_clk);
		chk(24'(bufRdData), 24'h0000a5);
		// single load then two burst loads
		bus(`NVMC_EE_MAP_BASE + 24'h123, 1'b0, 8'h00);
		chk(24'(lat), 24'h000003);
		chk(24'(rdata), 24'(8'h23 ^ 8'h5a));
		for (int k = 4; k < 6; k++) begin
			bus(`NVMC_EE_MAP_BASE + 24'h120 + 24'(k), 1'b0, 8'h00);
			chk(24'(lat), 24'h000002);
			chk(24'(rdata), 24'(8'(8'h20 + k) ^ 8'h5a));
		end
		idle();
		// flush under an open guard; a second trigger while busy is refused
		guardOpen = 1'b1;
		wr(`NVMC_OFF_EXEC_CTRL, 8'h01);
		wr(`NVMC_OFF_EXEC_CTRL, 8'h01);
		chk(24'(starts), 24'h000001);
		chk(24'(loaded), 24'h000000);
		rd(`NVMC_OFF_STATUS);
		chk(24'(rdata[7]), 24'h000001);
		waitIdle();
		bus(`NVMC_EE_MAP_BASE + 24'h7, 1'b1, 8'h3c);
		idle();
		wr(`NVMC_OFF_OPCODE, {1'b0, `NVMC_CMD_EE_PAGE_WRITE});
		wr(`NVMC_OFF_EXEC_CTRL, 8'h01);
		chk(24'(loaded), 24'h000000);
		waitIdle();
		// load command: a value low store fills the buffer at the location low byte
		wr(`NVMC_OFF_OPCODE, {1'b0, `NVMC_CMD_EE_LOAD});
		wr(`NVMC_OFF_LOC_LOW, 8'h09);
		wr(`NVMC_OFF_VAL_LOW, 8'h77);
		chk(24'(loaded), 24'h000001);
		bufRdAddr = 5'h09;
		@(negedge sys_clk);
		chk(24'(bufRdData), 24'h000077);
		// crc result lands in the value word
		crcResult = 24'habcdef;
		crcValid = 1'b1;
		@(negedge sys_clk);
		crcValid = 1'b0;
		rd(`NVMC_OFF_VAL_HIGH);
		chk(24'(rdata), 24'h0000ab);
		chk(nvmVal, 24'habcdef);
		// eeprom asleep: a load waits out the wake time
		wr(`NVMC_OFF_OPT_CTRL, 8'h0a);
		chk(24'(eePs), 24'h000001);
		bus(`NVMC_EE_MAP_BASE + 24'h10, 1'b0, 8'h00);
		idle();
		chk(24'(lat >= 3 + WAKE && lat < 12), 24'h000001);
		chk(24'(rdata), 24'(8'h10 ^ 8'h5a));
		chk(24'(eeAddr), 24'h000010);
		// flash save: boot section sleeps while the application runs
		wr(`NVMC_OFF_OPT_CTRL, 8'h04);
		chk(24'(flashPs), 24'h000001);
		{flashReq, flashBoot} = 2'b10;
		stallSpan();
		chk(24'(n), 24'h000000);
		flashBoot = 1'b1;
		stallSpan();
		chk(24'(n >= WAKE && n <= WAKE + 2), 24'h000001);
		flashReq = 1'b0;
		// lockout needs the guard, ignores zero, clears only on reset
		spmReq = 1'b1;
		guardOpen = 1'b0;
		wr(`NVMC_OFF_OPT_CTRL, 8'h01);
		chk(24'(lockout), 24'h000000);
		chk(24'(spmGo), 24'h000001);
		guardOpen = 1'b1;
		wr(`NVMC_OFF_OPT_CTRL, 8'h01);
		wr(`NVMC_OFF_OPT_CTRL, 8'h00);
		chk(24'(lockout), 24'h000001);
		chk(24'(spmGo), 24'h000000);
		reset = 1'b1;
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		chk(24'(lockout), 24'h000000);
		chk(nvmVal, 24'h000000);
		reportAndStop();
	end
endmodule // testbench
`default_nettype wire
